// *** arb_pkg.sv ***
// Shared types and constants for the three-wire bus arbiter
package arb_pkg;

  // Synchronizer depth for pins from outside the clock domain
  localparam int unsigned SYNC_STAGES = 2;

  // Negated level of the active-low pins, used as their reset value
  localparam logic PIN_NEGATED = 1'h1;

  // Bus output drive after reset: processor owns the bus
  localparam logic DRIVE_RESET = 1'h1;

  // Arbiter states: owner, grant, grant hold, release, external master
  typedef enum logic [2:0] {
    OWNER_ST,
    GRANT_ST,
    GRANT_HOLD_ST,
    RELEASE_ST,
    EXT_MASTER_ST
  } arb_state_e;

  // Status from the processor's own bus controller, same clock
  typedef struct packed {
    logic cycle_decided;  // Core has decided to run a bus cycle
    logic cycle_started;  // That cycle has begun on the bus
    logic strobe_active;  // Own address strobe asserted
    logic lock_active;    // Own bus-lock (read-modify-write) asserted
    logic halted;         // Halt or double-fault stop, for visibility only
  } core_s;

endpackage

// *** three_wire_bus_arbiter.sv ***
// Processor-side arbiter for the request / grant / acknowledge bus protocol
// How it works
// - Request and acknowledge pins pass two flip-flops before the arbiter reads them.
// - Grant is raised at once after a synchronized request unless blocked.
// - A decided but unstarted bus cycle delays the grant until it starts.
// - While the bus lock is active, request is ignored and grant stays negated.
// - The bus is given up only after any started cycle completes.
// - Request withdrawn without acknowledge still goes through release and external state before the processor owns the bus again.
// - Idle state negates grant and float, stays while request and acknowledge negated.
// - Request enters grant state, next clock moves to grant hold state.
// - Hold waits for acknowledge or request drop, then enters release state.
// - Release leads to external state, which returns idle when acknowledge negates.
// - States change on rising edges; grant pin changes on the falling edge.
// - With float true, outputs float after strobe and lock are both negated.
// - Outputs are driven again right after ownership returns to the processor.
// - A pending request after acknowledge regrants without any own bus cycle.
// - Arbitration works during run, reset, halt and double-fault stop.
`timescale 1ns/10ps

module three_wire_bus_arbiter
  import arb_pkg::*;
(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // Arbitration pins
  input  wire logic         bus_request_n,
  input  wire logic         grant_acknowledge_n,
  output logic              bus_grant_n,
  // Processor bus controller side
  input  wire arb_pkg::core_s core_in,
  output logic              bus_float,
  output logic              bus_drive,
  output logic              grant_blocked
);
  import arb_pkg::*;

  logic [SYNC_STAGES-1:0] req_sync_r;
  logic [SYNC_STAGES-1:0] ack_sync_r;
  arb_state_e             state_r;
  arb_state_e             state_nxt;
  logic                   grant_r;
  logic                   drive_r;
  logic                   drive_nxt;

  // Synchronized, active-high versions of the pins
  wire req_w        = ~req_sync_r[SYNC_STAGES-1];
  wire ack_w        = ~ack_sync_r[SYNC_STAGES-1];
  // Lock or a committed but unstarted cycle keeps the grant back
  wire pend_cycle_w = core_in.cycle_decided & ~core_in.cycle_started;
  wire block_w      = core_in.lock_active | pend_cycle_w;
  wire start_w      = req_w & ~block_w;
  // Grant and float decoded from the state
  wire grant_st_w   = (state_r == GRANT_ST) | (state_r == GRANT_HOLD_ST);
  wire float_st_w   = (state_r != OWNER_ST);
  // Own bus is idle once strobe and lock are gone
  wire bus_quiet_w  = ~core_in.strobe_active & ~core_in.lock_active;

  assign grant_blocked = req_w & block_w;
  assign bus_float     = float_st_w;
  assign bus_grant_n   = ~grant_r;
  assign bus_drive     = drive_r;

  // Pins are asynchronous to the clock
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      req_sync_r <= {SYNC_STAGES{PIN_NEGATED}};
      ack_sync_r <= {SYNC_STAGES{PIN_NEGATED}};
    end
    else
    begin
      req_sync_r <= {req_sync_r[SYNC_STAGES-2:0], bus_request_n};
      ack_sync_r <= {ack_sync_r[SYNC_STAGES-2:0], grant_acknowledge_n};
    end
  end

  // Halt (core_in.halted) is not decoded and the processor reset pin is not an input here, so arbitration
  // carries on through them
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      OWNER_ST:
        if (start_w)
          state_nxt = GRANT_ST;
      GRANT_ST:
        state_nxt = GRANT_HOLD_ST;
      GRANT_HOLD_ST:
        if (ack_w || !req_w)
          state_nxt = RELEASE_ST;
      RELEASE_ST:
        state_nxt = EXT_MASTER_ST;
      EXT_MASTER_ST:
        if (!ack_w)
          state_nxt = OWNER_ST;
        else if (req_w)
          state_nxt = GRANT_ST;
      default:
        state_nxt = OWNER_ST;
    endcase
  end

  // Drive held until the own cycle and any lock have ended
  always_comb
  begin
    drive_nxt = drive_r;
    if (state_nxt == OWNER_ST)
      drive_nxt = 1'h1;
    else if (float_st_w && bus_quiet_w)
      drive_nxt = 1'h0;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= OWNER_ST;
      drive_r <= DRIVE_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      drive_r <= drive_nxt;
    end
  end

  // Grant pin moves half a clock after the state, giving setup margin
  always_ff @(negedge clock or negedge nrst)
  begin
    if (!nrst)
      grant_r <= 1'h0;
    else
      grant_r <= grant_st_w;
  end

  // Checks
  property p_sync;
    @(posedge clock) disable iff (!nrst)
    req_sync_r[SYNC_STAGES-1] == $past(bus_request_n, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("request sync depth wrong");

  property p_grant_start;
    @(posedge clock) disable iff (!nrst)
    (state_r == OWNER_ST && req_w && !block_w) |=> (state_r == GRANT_ST);
  endproperty
  a_grant_start: assert property (p_grant_start) else $error("grant not started");

  property p_defer;
    @(posedge clock) disable iff (!nrst)
    (state_r == OWNER_ST && pend_cycle_w) |=> (state_r == OWNER_ST) && bus_grant_n;
  endproperty
  a_defer: assert property (p_defer) else $error("grant before cycle start");

  property p_lock;
    @(posedge clock) disable iff (!nrst)
    (state_r == OWNER_ST && core_in.lock_active) |=> !float_st_w && bus_grant_n;
  endproperty
  a_lock: assert property (p_lock) else $error("grant during lock");

  property p_hold;
    @(posedge clock) disable iff (!nrst)
    (state_r == GRANT_ST) |=> (state_r == GRANT_HOLD_ST) && bus_float;
  endproperty
  a_hold: assert property (p_hold) else $error("grant hold missed");

  property p_release;
    @(posedge clock) disable iff (!nrst)
    (state_r == GRANT_HOLD_ST && (ack_w || !req_w))
      |=> (state_r == RELEASE_ST) ##1 (state_r == EXT_MASTER_ST);
  endproperty
  a_release: assert property (p_release) else $error("release sequence broken");

  property p_return;
    @(posedge clock) disable iff (!nrst)
    (state_r == EXT_MASTER_ST && !ack_w) |=> !bus_float && bus_drive;
  endproperty
  a_return: assert property (p_return) else $error("ownership not returned");

  property p_pin;
    @(posedge clock) disable iff (!nrst)
    grant_st_w == !bus_grant_n;
  endproperty
  a_pin: assert property (p_pin) else $error("grant pin out of step");

  property p_float;
    @(posedge clock) disable iff (!nrst)
    (bus_float && !core_in.strobe_active && !core_in.lock_active && state_nxt != OWNER_ST)
      |=> !bus_drive;
  endproperty
  a_float: assert property (p_float) else $error("outputs not floated");

  property p_keep_drive;
    @(posedge clock) disable iff (!nrst)
    (bus_drive && (core_in.strobe_active || core_in.lock_active)) |=> bus_drive;
  endproperty
  a_keep_drive: assert property (p_keep_drive) else $error("bus dropped mid cycle");

  property p_regrant;
    @(posedge clock) disable iff (!nrst)
    (state_r == EXT_MASTER_ST && ack_w && req_w) |=> (state_r == GRANT_ST) && !bus_drive;
  endproperty
  a_regrant: assert property (p_regrant) else $error("no regrant");

endmodule

// *** ext_master.sv ***
// External bus master model on the arbitration pins
`timescale 1ns/10ps
module ext_master
(
  // Clock, reset and test control
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic want,
  input  wire logic other_req,
  input  wire logic strobe_active,
  input  wire logic lock_active,
  // Arbitration pins
  input  wire logic bus_grant_n,
  output logic      bus_request_n,
  output logic      grant_acknowledge_n,
  output logic      bus_error_n
);
  logic       req_r;
  logic [3:0] hold_r;
  assign bus_request_n = !(req_r || other_req);
  // Request alone is not honoured under lock, so abort it
  assign bus_error_n   = !((req_r || other_req) && lock_active);
  always_ff @(negedge clock or negedge nrst)
    if (!nrst)
    begin
      req_r               <= 1'h0;
      grant_acknowledge_n <= 1'h1;
    end
    else if (!grant_acknowledge_n)
    begin
      hold_r              <= hold_r - 4'h1;
      grant_acknowledge_n <= (hold_r == 4'h0);
    end
    else if (req_r && !bus_grant_n && !strobe_active)
    begin
      grant_acknowledge_n <= 1'h0;
      req_r               <= 1'h0;
      hold_r              <= 4'hC;
    end
    else
      req_r <= want;
endmodule

// *** three_wire_bus_arbiter_test.sv ***
// Self-checking bench for the three-wire bus arbiter
`timescale 1ns/10ps
module three_wire_bus_arbiter_test;
  import arb_pkg::*;
  logic  clock = 1'h0, nrst = 1'h0, want = 1'h0, other_req = 1'h0;
  logic  bus_request_n, grant_acknowledge_n, bus_grant_n, bus_float, bus_drive, grant_blocked;
  logic  bus_error_n;
  core_s core_in = '0;
  int    n_errors = 0, num_checks = 0;
  three_wire_bus_arbiter i_three_wire_bus_arbiter (.clock, .nrst, .bus_request_n,
    .grant_acknowledge_n, .bus_grant_n, .core_in, .bus_float, .bus_drive, .grant_blocked);
  ext_master i_ext_master (.clock, .nrst, .want, .other_req,
    .strobe_active(core_in.strobe_active), .lock_active(core_in.lock_active),
    .bus_grant_n, .bus_request_n, .grant_acknowledge_n, .bus_error_n);
  initial forever #25 clock = ~clock;
  task automatic check(input logic [3:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Sample past the falling edge so the grant flop has settled
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
    #2;
  endtask
  task automatic await(ref logic s, input logic lvl);
    for (int i = 0; i < 40 && s !== lvl; i++)
      cyc(1);
    check(s, lvl);
    if (s !== lvl)
      final_report();
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Second master keeps requesting, so the grant must come back
  task automatic t_grant();
    {want, other_req} = 2'h3;
    // Own cycle in flight and core halted while the request arrives
    core_in = '{strobe_active: 1'h1, halted: 1'h1, default: 1'h0};
    cyc(2);
    check(bus_grant_n, 1'h1);
    cyc(1);
    check({bus_grant_n, bus_float}, 2'h1);
    check(bus_drive, 1'h1);
    core_in.strobe_active = 1'h0;
    await(grant_acknowledge_n, 1'h0);
    check(bus_drive, 1'h0);
    want = 1'h0;
    await(bus_grant_n, 1'h1);
    await(bus_grant_n, 1'h0);
    check({grant_acknowledge_n, bus_drive}, 2'h0);
    other_req = 1'h0;
    await(bus_float, 1'h0);
    check(bus_drive, 1'h1);
    $display("test grant done");
  endtask
  task automatic t_hold_off();
    core_in.lock_active = 1'h1;
    other_req = 1'h1;
    cyc(8);
    check({bus_grant_n, grant_blocked}, 2'h3);
    check(bus_error_n, 1'h0);
    core_in = '{cycle_decided: 1'h1, default: 1'h0};
    cyc(4);
    check({bus_grant_n, grant_blocked}, 2'h3);
    core_in.cycle_started = 1'h1;
    await(bus_grant_n, 1'h0);
    core_in = '0;
    other_req = 1'h0;
    await(bus_float, 1'h0);
    $display("test hold off done");
  endtask
  initial
  begin
    cyc(3);
    nrst = 1'h1;
    check({bus_grant_n, bus_float, bus_drive}, 3'h5);
    t_grant();
    t_hold_off();
    final_report();
  end
endmodule
